// ### verilog/rtcio_top.sv
module rtcio_top #(
  parameter int PULSE_CYCLES = rtcio_pkg::PULSE_CYCLES
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic [16:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic        wdog_timeout,
  input  wire logic        pfail_detect,
  input  wire logic        alarm_rest_match,
  input  wire logic [7:0]  cur_day,
  output logic             event_pin_o,
  output logic             event_pin_oe_b,
  output logic             alarm_match_o
);

  logic [7:0]                routing_r;
  logic [7:0]                alarm_day_r;
  logic [2:0]                flags_r;
  logic [2:0]                flags_nxt;
  logic                      flags_rd;
  logic                      alarm_hit;
  logic                      alarm_hit_d_r;
  logic                      alarm_evt;
  logic                      routed_evt;
  logic                      pulse_busy;
  logic                      active;
  rtcio_pkg::rtcio_state_t   state_r;

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // Reserved bits are forced to zero so they read back as zero.
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      routing_r   <= rtcio_pkg::RST_ROUTING;
      alarm_day_r <= rtcio_pkg::RST_ALARM_DAY;
    end
    else if (reg_wr)
    begin
      if (reg_addr == rtcio_pkg::OFS_ROUTING)
        routing_r <= reg_wdata & rtcio_pkg::ROUTING_MASK;
      if (reg_addr == rtcio_pkg::OFS_ALARM_DAY)
        alarm_day_r <= reg_wdata & rtcio_pkg::ALARM_MASK;
    end
  end

  // ----------------------------------------------------------------
  // Alarm comparison
  // ----------------------------------------------------------------
  // Only the rising edge of a match counts, so a match lasting a whole day fires once.
  always_comb
  begin
    if (alarm_day_r[rtcio_pkg::BIT_DAY_BYPASS])
      alarm_hit = alarm_rest_match;
    else
      alarm_hit = alarm_rest_match && (cur_day[5:0] == alarm_day_r[5:0]);
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      alarm_hit_d_r <= 1'b0;
    else
      alarm_hit_d_r <= alarm_hit;
  end

  assign alarm_evt = alarm_hit && !alarm_hit_d_r;

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      alarm_match_o <= 1'b0;
    else
      alarm_match_o <= alarm_evt;
  end

  // ----------------------------------------------------------------
  // Flags: set wins over the clear-on-read
  // ----------------------------------------------------------------
  assign flags_rd = reg_rd && (reg_addr == rtcio_pkg::OFS_FLAGS);

  always_comb
  begin
    flags_nxt = flags_rd ? 3'h0 : flags_r;
    if (wdog_timeout)
      flags_nxt[2] = 1'b1;
    if (alarm_evt)
      flags_nxt[1] = 1'b1;
    if (pfail_detect)
      flags_nxt[0] = 1'b1;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      flags_r <= 3'h0;
    else
      flags_r <= flags_nxt;
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // Unmapped addresses read zero; data stand one cycle after the strobe only.
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      reg_rdata <= 8'h00;
    else if (!reg_rd)
      reg_rdata <= 8'h00;
    else if (reg_addr == rtcio_pkg::OFS_ROUTING)
      reg_rdata <= routing_r;
    else if (reg_addr == rtcio_pkg::OFS_ALARM_DAY)
      reg_rdata <= alarm_day_r;
    else if (reg_addr == rtcio_pkg::OFS_FLAGS)
      reg_rdata <= {flags_r, 5'h00};
    else if (reg_addr == rtcio_pkg::OFS_CUR_DAY)
      reg_rdata <= cur_day;
    else
      reg_rdata <= 8'h00;
  end

  // ----------------------------------------------------------------
  // Event routing to the output pin
  // ----------------------------------------------------------------
  assign routed_evt = (wdog_timeout && routing_r[rtcio_pkg::BIT_WDOG_EN])
                   || (alarm_evt && routing_r[rtcio_pkg::BIT_ALARM_EN])
                   || (pfail_detect && routing_r[rtcio_pkg::BIT_PFAIL_EN]);

  rtcio_pulse_timer #(
    .CYCLES (PULSE_CYCLES)
  ) u_pulse (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .start   (routed_evt && routing_r[rtcio_pkg::BIT_PULSE]),
    .busy    (pulse_busy)
  );

  // Output state: pulse ends on the timer, level ends on a flags read.
  // An event in the same cycle as the read keeps the line active.
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      state_r <= rtcio_pkg::RTCIO_IDLE;
    else if (routed_evt)
      state_r <= routing_r[rtcio_pkg::BIT_PULSE] ? rtcio_pkg::RTCIO_PULSE
                                                  : rtcio_pkg::RTCIO_LEVEL;
    else
    begin
      unique case (state_r)
        rtcio_pkg::RTCIO_IDLE:  state_r <= rtcio_pkg::RTCIO_IDLE;
        rtcio_pkg::RTCIO_PULSE: if (!pulse_busy) state_r <= rtcio_pkg::RTCIO_IDLE;
        rtcio_pkg::RTCIO_LEVEL: if (flags_rd) state_r <= rtcio_pkg::RTCIO_IDLE;
        default:                state_r <= rtcio_pkg::RTCIO_IDLE;
      endcase
    end
  end

  assign active = (state_r != rtcio_pkg::RTCIO_IDLE);

  // Polarity one: pushed both ways. Polarity zero: pulled low only, released otherwise.
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      event_pin_o    <= 1'b0;
      event_pin_oe_b <= 1'b1;
    end
    else if (routing_r[rtcio_pkg::BIT_POLARITY])
    begin
      event_pin_o    <= active;
      event_pin_oe_b <= 1'b0;
    end
    else
    begin
      event_pin_o    <= 1'b0;
      event_pin_oe_b <= !active;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_wdog_flag_set: assert property (@(posedge sys_clk) disable iff (!rst_b)
    wdog_timeout |=> flags_r[2]) else $error("watchdog flag not set");
  a_alarm_flag_set: assert property (@(posedge sys_clk) disable iff (!rst_b)
    alarm_evt |=> flags_r[1]) else $error("alarm flag not set");
  a_pfail_flag_set: assert property (@(posedge sys_clk) disable iff (!rst_b)
    pfail_detect |=> flags_r[0]) else $error("power fail flag not set");
  a_masked_quiet: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (!active && !routed_evt) |=> !active) else $error("line active without routed event");
  a_high_drive: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (routing_r[rtcio_pkg::BIT_POLARITY] && active) |=> (event_pin_o && !event_pin_oe_b))
    else $error("active high drive wrong");
  a_open_drain: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (!routing_r[rtcio_pkg::BIT_POLARITY] && active) |=> (!event_pin_o && !event_pin_oe_b))
    else $error("open drain drive wrong");
  a_pulse_starts: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (routed_evt && routing_r[rtcio_pkg::BIT_PULSE]) |=> (state_r == rtcio_pkg::RTCIO_PULSE) ##1 pulse_busy)
    else $error("pulse did not start");
  a_level_holds: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ((state_r == rtcio_pkg::RTCIO_LEVEL) && !flags_rd) |=> active)
    else $error("level released without read");
  a_day_compare: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (alarm_rest_match && !alarm_day_r[7] && (cur_day[5:0] != alarm_day_r[5:0])) |-> !alarm_hit)
    else $error("date ignored while compared");

  c_pulse: cover property (@(posedge sys_clk) state_r == rtcio_pkg::RTCIO_PULSE ##1 !active);
  c_level: cover property (@(posedge sys_clk) state_r == rtcio_pkg::RTCIO_LEVEL ##1 flags_rd);
  c_masked: cover property (@(posedge sys_clk) wdog_timeout && !routed_evt);

endmodule

// ### verilog/rtcio_pkg.sv
package rtcio_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [16:0] OFS_ROUTING   = 17'h1fff6;
  localparam logic [16:0] OFS_ALARM_DAY = 17'h1fff5;
  localparam logic [16:0] OFS_FLAGS     = 17'h1fff0;
  localparam logic [16:0] OFS_CUR_DAY   = 17'h1ffe0;

  // ----------------------------------------------------------------
  // Field positions of the routing control register
  // ----------------------------------------------------------------
  localparam int BIT_WDOG_EN  = 7;
  localparam int BIT_ALARM_EN = 6;
  localparam int BIT_PFAIL_EN = 5;
  localparam int BIT_POLARITY = 3;
  localparam int BIT_PULSE    = 2;

  // ----------------------------------------------------------------
  // Field positions of the flags register and the alarm day register
  // ----------------------------------------------------------------
  localparam int BIT_WDOG_FLAG  = 7;
  localparam int BIT_ALARM_FLAG = 6;
  localparam int BIT_PFAIL_FLAG = 5;
  localparam int BIT_DAY_BYPASS = 7;

  // ----------------------------------------------------------------
  // Reset values and masks
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_ROUTING   = 8'h00;
  localparam logic [7:0] RST_ALARM_DAY = 8'h00;
  localparam logic [7:0] ROUTING_MASK  = 8'hec;
  localparam logic [7:0] ALARM_MASK    = 8'hbf;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ      = 250;
  localparam int PULSE_MS     = 200;
  localparam int PULSE_CYCLES = PULSE_MS * CLK_MHZ * 1000;

  typedef enum logic [1:0] {
    RTCIO_IDLE  = 2'b00,
    RTCIO_PULSE = 2'b01,
    RTCIO_LEVEL = 2'b10
  } rtcio_state_t;

endpackage

// ### verilog/rtcio_pulse_timer.sv
// Down counter that times one fixed-length output pulse.
module rtcio_pulse_timer #(
  parameter int CYCLES = rtcio_pkg::PULSE_CYCLES
) (
  input  wire logic sys_clk,
  input  wire logic rst_b,
  input  wire logic start,
  output logic      busy
);

  logic [31:0] count_r;

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  // A new start while busy restarts the full length, so the line stays active.
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      count_r <= 32'h0;
    else if (start)
      count_r <= 32'(CYCLES);
    else if (count_r != 32'h0)
      count_r <= count_r - 32'h1;
  end

  assign busy = (count_r != 32'h0);

endmodule

// ### verification/rtcio_host_model.sv
// ----------------------------------------------------------------
// Host side of the event line
// ----------------------------------------------------------------
module rtcio_host_model (
  input  wire logic event_pin_o,
  input  wire logic event_pin_oe_b,
  output logic      pin_level
);
  timeunit 1ns;
  timeprecision 1ps;

  // A released line floats up to the host's pull-up, never to the last driven value.
  assign pin_level = event_pin_oe_b ? 1'b1 : event_pin_o;
endmodule

// ### verification/tb.sv
// ----------------------------------------------------------------
// Self-checking bench for the event output block
// ----------------------------------------------------------------
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        sys_clk, rst_b, reg_wr, reg_rd, wdog_timeout, pfail_detect, alarm_rest_match;
  logic [16:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, cur_day, d;
  logic        event_pin_o, event_pin_oe_b, alarm_match_o, pin_level;
  int          miscompares, checks_done, n, alarm_pulses;

  // A short pulse keeps the pulse scenario to a few dozen cycles.
  rtcio_top #(.PULSE_CYCLES(20)) dut (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .wdog_timeout(wdog_timeout), .pfail_detect(pfail_detect), .alarm_rest_match(alarm_rest_match),
    .cur_day(cur_day), .event_pin_o(event_pin_o), .event_pin_oe_b(event_pin_oe_b),
    .alarm_match_o(alarm_match_o));
  rtcio_host_model host (.event_pin_o(event_pin_o), .event_pin_oe_b(event_pin_oe_b), .pin_level(pin_level));

  // Free-running 250 MHz clock.
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // Counts the cycles in which the alarm pulse output stands high; each alarm event owes exactly one.
  always @(posedge sys_clk)
    if (alarm_match_o === 1'b1)
      alarm_pulses++;

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (exp !== got)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [16:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data is looked at only in the single cycle after the strobe.
  task automatic rd(input logic [16:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  task automatic rdchk(input string what, input logic [16:0] a, input logic [7:0] exp);
    rd(a, d);
    chk(what, exp, d);
  endtask

  // Source 0 is the watchdog, 1 the alarm, 2 power fail.
  task automatic ev(input int k);
    @(posedge sys_clk);
    if (k == 0) wdog_timeout <= 1'b1;
    else if (k == 1) alarm_rest_match <= 1'b1;
    else pfail_detect <= 1'b1;
    @(posedge sys_clk);
    {wdog_timeout, alarm_rest_match, pfail_detect} <= 3'h0;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {rst_b, reg_wr, reg_rd, wdog_timeout, pfail_detect, alarm_rest_match} = 6'h00;
    reg_addr = 17'h00000;
    reg_wdata = 8'h00;
    cur_day = 8'h03;
    miscompares = 0;
    checks_done = 0;
    alarm_pulses = 0;
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    rdchk("routing_rst", rtcio_pkg::OFS_ROUTING, 8'h00);
    rdchk("alarm_rst", rtcio_pkg::OFS_ALARM_DAY, 8'h00);
    wr(17'h00123, 8'hff);
    rdchk("unmapped", 17'h00123, 8'h00);
    wr(rtcio_pkg::OFS_ROUTING, 8'hff);
    rdchk("routing_mask", rtcio_pkg::OFS_ROUTING, 8'hec);
    wr(rtcio_pkg::OFS_ALARM_DAY, 8'hff);
    rdchk("alarm_mask", rtcio_pkg::OFS_ALARM_DAY, 8'hbf);
    rdchk("cur_day", rtcio_pkg::OFS_CUR_DAY, 8'h03);
    $display("test registers done");
    // Disabled sources set their flag only; the open-drain line stays released.
    wr(rtcio_pkg::OFS_ROUTING, 8'h00);
    wr(rtcio_pkg::OFS_ALARM_DAY, 8'h80);
    for (int k = 0; k < 3; k++)
    begin
      ev(k);
      chk("pin_disabled", 8'h01, {7'h00, pin_level});
      rdchk("flag_disabled", rtcio_pkg::OFS_FLAGS, 8'h80 >> k);
      rdchk("flag_cleared", rtcio_pkg::OFS_FLAGS, 8'h00);
    end
    $display("test disabled sources done");
    // Enabled sources hold the line in level mode until the host reads the flags.
    for (int k = 0; k < 6; k++)
    begin
      wr(rtcio_pkg::OFS_ROUTING, (8'h80 >> (k % 3)) | ((k < 3) ? 8'h08 : 8'h00));
      ev(k % 3);
      chk("pin_active", {7'h00, k < 3}, {7'h00, pin_level});
      repeat (10) @(posedge sys_clk);
      #1 chk("pin_held", {7'h00, k < 3}, {7'h00, pin_level});
      rdchk("flag_enabled", rtcio_pkg::OFS_FLAGS, 8'h80 >> (k % 3));
      repeat (2) @(posedge sys_clk);
      #1 chk("pin_release", {7'h00, k >= 3}, {7'h00, pin_level});
    end
    $display("test level mode done");
    // Pulse mode: the line is active for the pulse length, then drops by itself.
    wr(rtcio_pkg::OFS_ROUTING, 8'h8c);
    ev(0);
    n = 0;
    while (pin_level === 1'b1 && n < 100)
    begin
      @(posedge sys_clk);
      #1 n++;
    end
    chk("pulse_len", 8'h01, {7'h00, n >= 16 && n <= 22});
    rdchk("flag_pulse", rtcio_pkg::OFS_FLAGS, 8'h80);
    $display("test pulse mode done");
    // The date takes part in matching unless bypassed.
    wr(rtcio_pkg::OFS_ALARM_DAY, 8'h05);
    ev(1);
    rdchk("date_miss", rtcio_pkg::OFS_FLAGS, 8'h00);
    chk("alarm_pulses", 8'h03, alarm_pulses[7:0]);
    @(posedge sys_clk) cur_day <= 8'h05;
    ev(1);
    rdchk("date_hit", rtcio_pkg::OFS_FLAGS, 8'h40);
    chk("alarm_pulses", 8'h04, alarm_pulses[7:0]);
    @(posedge sys_clk) cur_day <= 8'h03;
    wr(rtcio_pkg::OFS_ALARM_DAY, 8'h85);
    ev(1);
    rdchk("date_bypass", rtcio_pkg::OFS_FLAGS, 8'h40);
    chk("alarm_pulses", 8'h05, alarm_pulses[7:0]);
    $display("test date match done");
    conclude();
  end
endmodule
